// file: hw/card_socket_event_interrupts.sv
// per-socket card event detection, flags, masks and interrupt routing
//
// What this block does
// - memory card: battery detect changes set legacy flags 1,0, masks 1,0
// - memory card: ready transition sets legacy flag 2, masked by bit 2
// - I/O card: status change assertion sets legacy flag 0, mask bit 0
// - card irq request assertion sets config byte 91h bit 0, always on
// - wide card: status change assertion sets socket event bit 0, mask 0
// - card detect transitions set socket event bits 2,1, masks 2,1
// - power-up done: legacy bit 3 for 16-bit, socket bit 3 for wide
// - insertion and removal detected whatever card kind is present
// - no functional interrupts while a memory card is present
// - functional interrupts have no mask and always pass through
// - each status change source can be masked individually
// - every source keeps a readable flag, masked or not
// - status change and functional interrupts route to separately selected lines, which may coincide
// - legacy flags clear by writing one or by reading the register
// - global control bit 2 picks the clear method, read-clear after reset
// - socket event flags clear only on a written one
`timescale 1ns/1ps
`default_nettype none

module card_socket_event_interrupts
  import card_socket_irq_pkg::*;
#(
  parameter int NUM_SOCKETS = NUM_SOCKETS_DEF,
  parameter int NUM_LINES   = NUM_LINES_DEF,
  localparam int SW = (NUM_SOCKETS > 1) ? $clog2(NUM_SOCKETS) : 1,
  localparam int LW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire card_pins_t [NUM_SOCKETS-1:0]  pins,
  input  wire card_kind_t [NUM_SOCKETS-1:0]  card_kind,
  input  wire logic [NUM_SOCKETS-1:0]        power_cycle_done,
  input  wire logic [LW-1:0]                 csc_route,
  input  wire logic [LW-1:0]                 func_route,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire reg_space_t                    reg_space,
  input  wire logic [SW-1:0]                 reg_socket,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  output logic [31:0]                        reg_rdata,
  output logic [NUM_SOCKETS-1:0]             csc_irq,
  output logic [NUM_SOCKETS-1:0]             func_irq,
  output logic [NUM_LINES-1:0]               irq_lines
);

  socket_state_t [NUM_SOCKETS-1:0] st_reg;
  socket_state_t [NUM_SOCKETS-1:0] st_next;
  logic [31:0]                     rdata_reg;
  logic [31:0]                     rdata_next;

  // transition of a level between two samples
  function automatic logic changed(input logic now_v, input logic old_v);
    return now_v ^ old_v;
  endfunction

  // assertion of a level between two samples
  function automatic logic rose(input logic now_v, input logic old_v);
    return now_v & ~old_v;
  endfunction

  function automatic logic hit(input reg_space_t sp, input logic [7:0] ofs,
                               input reg_space_t want_sp,
                               input logic [7:0] want_ofs);
    return (sp == want_sp) && (ofs == want_ofs);
  endfunction

  always_comb begin
    logic       sel;
    logic       primed;
    logic       wr_flags;
    logic       rd_clear;
    logic [7:0] lset;
    logic [3:0] sset;
    logic       fset;
    card_pins_t p;
    card_pins_t q;
    sel      = 1'b0;
    primed   = 1'b0;
    wr_flags = 1'b0;
    rd_clear = 1'b0;
    lset     = 8'h00;
    sset     = 4'h0;
    fset     = 1'b0;
    p        = '0;
    q        = '0;
    st_next  = st_reg;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      sel    = (reg_socket == SW'(s));
      primed = st_reg[s].primed;
      p      = pins[s];
      q      = st_reg[s].prev_pins;
      lset   = 8'h00;
      sset   = 4'h0;
      fset   = 1'b0;
      if (primed) begin
        case (card_kind[s])
          KIND_MEM16: begin
            lset[BIT_BATT_ONE] = changed(p.battery_detect_one,
                                         q.battery_detect_one);
            lset[BIT_BATT_TWO] = changed(p.battery_detect_two,
                                         q.battery_detect_two);
            lset[BIT_READY] = changed(p.card_ready, q.card_ready);
          end
          KIND_IO16: begin
            lset[BIT_LEGACY_STATUS_CHANGE_INPUT] = rose(p.legacy_status_change_input,
                                    q.legacy_status_change_input);
            fset = rose(p.legacy_card_irq_request,
                        q.legacy_card_irq_request);
          end
          KIND_WIDE: begin
            sset[BIT_SOCK_LEGACY_STATUS_CHANGE_INPUT] = rose(
              p.wide_card_status_change_input,
              q.wide_card_status_change_input);
            fset = rose(p.wide_card_irq_input, q.wide_card_irq_input);
          end
          default: begin
            fset = 1'b0;
          end
        endcase
        // detect changes for every kind, both pin pairs watched
        sset[BIT_DETECT_ONE] = changed(p.card_detect_one, q.card_detect_one)
          | changed(p.wide_card_detect_one, q.wide_card_detect_one);
        sset[BIT_DETECT_TWO] = changed(p.card_detect_two, q.card_detect_two)
          | changed(p.wide_card_detect_two, q.wide_card_detect_two);
      end
      if (power_cycle_done[s]) begin
        if (card_kind[s] == KIND_WIDE) begin
          sset[BIT_POWER_DONE] = 1'b1;
        end else begin
          lset[BIT_POWER_DONE] = 1'b1;
        end
      end

      wr_flags = sel && reg_wr
                 && hit(reg_space, reg_addr, SPACE_LEGACY, LEGACY_FLAGS_OFS);
      rd_clear = sel && reg_rd
                 && hit(reg_space, reg_addr, SPACE_LEGACY, LEGACY_FLAGS_OFS)
                 && !st_reg[s].legacy_global_control[BIT_FLAG_CLEAR];
      if (rd_clear) begin
        st_next[s].legacy_status_change_flags = 8'h00;
      end else if (wr_flags
                   && st_reg[s].legacy_global_control[BIT_FLAG_CLEAR]) begin
        st_next[s].legacy_status_change_flags =
          st_reg[s].legacy_status_change_flags & ~reg_wdata[7:0];
      end
      if (sel && reg_wr
          && hit(reg_space, reg_addr, SPACE_LEGACY, LEGACY_MASK_OFS)) begin
        st_next[s].legacy_status_change_mask = reg_wdata[7:0];
      end
      if (sel && reg_wr
          && hit(reg_space, reg_addr, SPACE_LEGACY, LEGACY_GCTL_OFS)) begin
        st_next[s].legacy_global_control = reg_wdata[7:0];
      end
      if (sel && reg_wr
          && hit(reg_space, reg_addr, SPACE_SOCKET, SOCK_EVENT_OFS)) begin
        st_next[s].socket_event_flags =
          st_reg[s].socket_event_flags & ~reg_wdata[3:0];
      end
      if (sel && reg_wr
          && hit(reg_space, reg_addr, SPACE_SOCKET, SOCK_MASK_OFS)) begin
        st_next[s].socket_event_mask = reg_wdata[3:0];
      end
      if (sel && reg_wr && reg_wdata[BIT_FUNC_FLAG]
          && hit(reg_space, reg_addr, SPACE_CONFIG, FUNC_FLAG_OFS)) begin
        st_next[s].functional_interrupt_flag = 1'b0;
      end

      // new events win over a clear in the same cycle
      st_next[s].legacy_status_change_flags =
        st_next[s].legacy_status_change_flags | lset;
      st_next[s].socket_event_flags =
        st_next[s].socket_event_flags | sset;
      st_next[s].functional_interrupt_flag =
        st_next[s].functional_interrupt_flag | fset;
      st_next[s].prev_pins = p;
      st_next[s].primed    = 1'b1;
    end
  end

  // read data, one socket selected
  always_comb begin
    socket_state_t cur;
    cur        = st_reg[0];
    rdata_next = rdata_reg;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      if (reg_socket == SW'(s)) begin
        cur = st_reg[s];
      end
    end
    if (reg_rd) begin
      rdata_next = 32'h0000_0000;
      if (hit(reg_space, reg_addr, SPACE_LEGACY, LEGACY_FLAGS_OFS)) begin
        rdata_next[7:0] = cur.legacy_status_change_flags;
      end else if (hit(reg_space, reg_addr, SPACE_LEGACY,
                       LEGACY_MASK_OFS)) begin
        rdata_next[7:0] = cur.legacy_status_change_mask;
      end else if (hit(reg_space, reg_addr, SPACE_LEGACY,
                       LEGACY_GCTL_OFS)) begin
        rdata_next[7:0] = cur.legacy_global_control;
      end else if (hit(reg_space, reg_addr, SPACE_CONFIG,
                       FUNC_FLAG_OFS)) begin
        rdata_next[BIT_FUNC_FLAG] = cur.functional_interrupt_flag;
      end else if (hit(reg_space, reg_addr, SPACE_SOCKET,
                       SOCK_EVENT_OFS)) begin
        rdata_next[3:0] = cur.socket_event_flags;
      end else if (hit(reg_space, reg_addr, SPACE_SOCKET,
                       SOCK_MASK_OFS)) begin
        rdata_next[3:0] = cur.socket_event_mask;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        st_reg[s].legacy_status_change_flags <= LEGACY_FLAGS_RST;
        st_reg[s].legacy_status_change_mask  <= LEGACY_MASK_RST;
        st_reg[s].legacy_global_control     <= LEGACY_GCTL_RST;
        st_reg[s].functional_interrupt_flag <= 1'b0;
        st_reg[s].socket_event_flags        <= SOCK_EVENT_RST;
        st_reg[s].socket_event_mask         <= SOCK_MASK_RST;
        st_reg[s].prev_pins                 <= '0;
        st_reg[s].primed                    <= 1'b0;
      end
      rdata_reg <= RDATA_RST;
    end else begin
      st_reg    <= st_next;
      rdata_reg <= rdata_next;
    end
  end

  // interrupt requests and routing
  always_comb begin
    irq_lines = '0;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      csc_irq[s] = |(st_reg[s].legacy_status_change_flags
                     & st_reg[s].legacy_status_change_mask)
                 | |(st_reg[s].socket_event_flags
                     & st_reg[s].socket_event_mask);
      func_irq[s] = ((card_kind[s] == KIND_IO16)
                     && st_reg[s].prev_pins.legacy_card_irq_request)
                  | ((card_kind[s] == KIND_WIDE)
                     && st_reg[s].prev_pins.wide_card_irq_input);
    end
    for (int l = 0; l < NUM_LINES; l++) begin
      if (csc_route == LW'(l)) begin
        irq_lines[l] = irq_lines[l] | (|csc_irq);
      end
      if (func_route == LW'(l)) begin
        irq_lines[l] = irq_lines[l] | (|func_irq);
      end
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

// file: hw/card_socket_irq_pkg.sv
// constants, types and register map for the socket event interrupt block
package card_socket_irq_pkg;

  localparam int          NUM_SOCKETS_DEF = 2;
  localparam int          NUM_LINES_DEF   = 4;

  // legacy socket register set offsets
  localparam logic [7:0]  LEGACY_FLAGS_OFS = 8'h04;
  localparam logic [7:0]  LEGACY_MASK_OFS  = 8'h05;
  localparam logic [7:0]  LEGACY_GCTL_OFS  = 8'h1E;
  // configuration byte holding the functional interrupt flag
  localparam logic [7:0]  FUNC_FLAG_OFS    = 8'h91;
  // wide card socket register set offsets
  localparam logic [7:0]  SOCK_EVENT_OFS   = 8'h00;
  localparam logic [7:0]  SOCK_MASK_OFS    = 8'h04;

  // field positions
  localparam int          BIT_BATT_ONE     = 0;
  localparam int          BIT_BATT_TWO     = 1;
  localparam int          BIT_READY        = 2;
  localparam int          BIT_LEGACY_STATUS_CHANGE_INPUT       = 0;
  localparam int          BIT_POWER_DONE   = 3;
  localparam int          BIT_SOCK_LEGACY_STATUS_CHANGE_INPUT  = 0;
  localparam int          BIT_DETECT_ONE   = 1;
  localparam int          BIT_DETECT_TWO   = 2;
  localparam int          BIT_FLAG_CLEAR   = 2;
  localparam int          BIT_FUNC_FLAG    = 0;

  // reset values
  localparam logic [7:0]  LEGACY_FLAGS_RST = 8'h00;
  localparam logic [7:0]  LEGACY_MASK_RST  = 8'h00;
  localparam logic [7:0]  LEGACY_GCTL_RST  = 8'h00;
  localparam logic [3:0]  SOCK_EVENT_RST   = 4'h0;
  localparam logic [3:0]  SOCK_MASK_RST    = 4'h0;
  localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

  typedef enum logic [1:0] {
    KIND_NONE  = 2'b00,
    KIND_MEM16 = 2'b01,
    KIND_IO16  = 2'b10,
    KIND_WIDE  = 2'b11
  } card_kind_t;

  typedef enum logic [1:0] {
    SPACE_LEGACY = 2'b00,
    SPACE_CONFIG = 2'b01,
    SPACE_SOCKET = 2'b10,
    SPACE_NONE   = 2'b11
  } reg_space_t;

  typedef struct packed {
    logic battery_detect_one;
    logic battery_detect_two;
    logic card_ready;
    logic legacy_status_change_input;
    logic legacy_card_irq_request;
    logic wide_card_status_change_input;
    logic wide_card_irq_input;
    logic card_detect_one;
    logic card_detect_two;
    logic wide_card_detect_one;
    logic wide_card_detect_two;
  } card_pins_t;

  typedef struct packed {
    logic [7:0] legacy_status_change_flags;
    logic [7:0] legacy_status_change_mask;
    logic [7:0] legacy_global_control;
    logic       functional_interrupt_flag;
    logic [3:0] socket_event_flags;
    logic [3:0] socket_event_mask;
    card_pins_t prev_pins;
    logic       primed;
  } socket_state_t;

endpackage

// file: verification/card_model.sv
// card side model driving the socket pins of both sockets
`timescale 1ns/1ps
`default_nettype none
module card_model
  import card_socket_irq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire card_pins_t [1:0] want_pins,
  output var  card_pins_t [1:0] pins
);
  card_pins_t [1:0] pins_reg;
  card_pins_t [1:0] pins_next;
  // pin levels change just after an edge and hold until changed
  always_comb begin
    pins_next = want_pins;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins_next;
    end
  end
  assign pins = pins_reg;
endmodule
`default_nettype wire

// file: verification/card_socket_event_interrupts_checker.sv
// port assertions for the socket event interrupt block
`timescale 1ns/1ps
`default_nettype none
module card_socket_event_interrupts_checker
  import card_socket_irq_pkg::*;
#(
  parameter int NUM_SOCKETS = NUM_SOCKETS_DEF,
  parameter int NUM_LINES   = NUM_LINES_DEF,
  localparam int SW = (NUM_SOCKETS > 1) ? $clog2(NUM_SOCKETS) : 1,
  localparam int LW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1
) (
  input wire logic                         clk,
  input wire logic                         resetn,
  input wire card_pins_t [NUM_SOCKETS-1:0] pins,
  input wire card_kind_t [NUM_SOCKETS-1:0] card_kind,
  input wire logic [NUM_SOCKETS-1:0]       power_cycle_done,
  input wire logic [LW-1:0]                csc_route,
  input wire logic [LW-1:0]                func_route,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire reg_space_t                   reg_space,
  input wire logic [SW-1:0]                reg_socket,
  input wire logic [7:0]                   reg_addr,
  input wire logic [31:0]                  reg_wdata,
  input wire logic [31:0]                  reg_rdata,
  input wire logic [NUM_SOCKETS-1:0]       csc_irq,
  input wire logic [NUM_SOCKETS-1:0]       func_irq,
  input wire logic [NUM_LINES-1:0]         irq_lines
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  chk_func_memory: assert property (
    (card_kind[0] == KIND_MEM16) [*2] |-> !func_irq[0])
    else $error("func on memory");
  chk_func_follow: assert property (
    (card_kind[0] == KIND_IO16 && $past(card_kind[0]) == KIND_IO16)
    |-> func_irq[0] == $past(pins[0].legacy_card_irq_request))
    else $error("io func");
  chk_wide_follow: assert property (
    (card_kind[1] == KIND_WIDE && $past(card_kind[1]) == KIND_WIDE)
    |-> func_irq[1] == $past(pins[1].wide_card_irq_input))
    else $error("wide func");
  chk_route_csc: assert property (
    csc_irq[0] |-> irq_lines[csc_route]) else $error("csc route");
  chk_route_func: assert property (
    func_irq[1] |-> irq_lines[func_route]) else $error("func route");
  chk_lines_idle: assert property (
    (csc_irq == '0 && func_irq == '0) |-> irq_lines == '0)
    else $error("idle lines");
  chk_rdata_hold: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
  chk_sock_width: assert property (
    reg_rd && reg_space == SPACE_SOCKET |=> reg_rdata[31:4] == '0)
    else $error("sock bits");
  cover property (csc_irq[0]);
  cover property (func_irq[1]);
  cover property (reg_rd && reg_space == SPACE_CONFIG);
endmodule
bind card_socket_event_interrupts card_socket_event_interrupts_checker #(
  .NUM_SOCKETS(NUM_SOCKETS), .NUM_LINES(NUM_LINES)) checker_inst (
  .clk(clk), .resetn(resetn), .pins(pins), .card_kind(card_kind),
  .power_cycle_done(power_cycle_done), .csc_route(csc_route),
  .func_route(func_route), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_space(reg_space), .reg_socket(reg_socket), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .csc_irq(csc_irq),
  .func_irq(func_irq), .irq_lines(irq_lines));
`default_nettype wire

// file: verification/card_socket_event_interrupts_tb.sv
// register level bench for the socket event interrupt block
`timescale 1ns/1ps
`default_nettype none
module card_socket_event_interrupts_tb;
  import card_socket_irq_pkg::*;
  logic             clk, resetn, reg_wr, reg_rd;
  logic [0:0]       sock;
  card_pins_t [1:0] want, pins;
  card_kind_t [1:0] kind;
  reg_space_t       space;
  logic [1:0]       pdone, csc_irq, func_irq, csc_route, func_route;
  logic [7:0]       addr;
  logic [31:0]      wdata, rdata;
  logic [3:0]       lines;
  int               fail_count, checked;
  card_model card_model_inst (.clk(clk), .resetn(resetn), .want_pins(want),
    .pins(pins));
  card_socket_event_interrupts card_socket_event_interrupts_inst (
    .clk(clk), .resetn(resetn), .pins(pins), .card_kind(kind),
    .power_cycle_done(pdone), .csc_route(csc_route), .func_route(func_route),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_space(space), .reg_socket(sock),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .csc_irq(csc_irq), .func_irq(func_irq), .irq_lines(lines));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(input logic k, input reg_space_t s, input logic [7:0] a,
                    input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    sock <= k;
    space <= s;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic k, input reg_space_t s, input logic [7:0] a,
                    input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    sock <= k;
    space <= s;
    addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg(n, e, rdata);
  endtask
  task automatic finish_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    fail_count = 0;
    checked = 0;
    resetn = 1'b0;
    {reg_wr, reg_rd, sock, pdone, addr, wdata} = '0;
    space = SPACE_NONE;
    want = '0;
    kind = {KIND_NONE, KIND_NONE};
    csc_route = 2'h0;
    func_route = 2'h1;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, '0, "flags rst");
    rd(0, SPACE_LEGACY, LEGACY_MASK_OFS, '0, "mask rst");
    rd(0, SPACE_LEGACY, LEGACY_GCTL_OFS, '0, "gctl rst");
    rd(0, SPACE_CONFIG, FUNC_FLAG_OFS, '0, "func rst");
    rd(1, SPACE_SOCKET, SOCK_MASK_OFS, '0, "smask rst");
    rd(0, SPACE_NONE, LEGACY_FLAGS_OFS, '0, "unmapped");
    kind[0] <= KIND_MEM16;
    repeat (3) @(posedge clk);
    want[0].battery_detect_one <= 1'b1;
    want[0].battery_detect_two <= 1'b1;
    want[0].card_ready <= 1'b1;
    want[0].legacy_card_irq_request <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk_bit("mem func", 1'b0, func_irq[0]);
    chk_bit("masked csc", 1'b0, csc_irq[0]);
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h7, "mem flags");
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, '0, "read clear");
    rd(0, SPACE_CONFIG, FUNC_FLAG_OFS, '0, "mem func flag");
    wr(0, SPACE_LEGACY, LEGACY_MASK_OFS, 32'h4);
    want[0].card_ready <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk_bit("ready csc", 1'b1, csc_irq[0]);
    chk_bit("csc line", 1'b1, lines[0]);
    chk_bit("other csc", 1'b0, csc_irq[1]);
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h4, "ready flag");
    chk_bit("csc cleared", 1'b0, csc_irq[0]);
    wr(0, SPACE_LEGACY, LEGACY_GCTL_OFS, 32'h4);
    want[0].battery_detect_one <= 1'b0;
    repeat (4) @(posedge clk);
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h1, "w1c flag");
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h1, "no rd clear");
    wr(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h2);
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h1, "zero kept");
    wr(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h1);
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, '0, "w1c done");
    kind[0] <= KIND_IO16;
    want[0].legacy_card_irq_request <= 1'b0;
    repeat (3) @(posedge clk);
    want[0].legacy_status_change_input <= 1'b1;
    want[0].legacy_card_irq_request <= 1'b1;
    pdone[0] <= 1'b1;
    @(posedge clk);
    pdone[0] <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk_bit("io func", 1'b1, func_irq[0]);
    chk_bit("func line", 1'b1, lines[1]);
    rd(0, SPACE_LEGACY, LEGACY_FLAGS_OFS, 32'h9, "io flags");
    rd(0, SPACE_CONFIG, FUNC_FLAG_OFS, 32'h1, "func flag");
    wr(0, SPACE_CONFIG, FUNC_FLAG_OFS, 32'h1);
    kind[1] <= KIND_WIDE;
    repeat (3) @(posedge clk);
    want[1].wide_card_status_change_input <= 1'b1;
    want[1].wide_card_irq_input <= 1'b1;
    want[1].card_detect_one <= 1'b1;
    want[1].wide_card_detect_two <= 1'b1;
    want[0].wide_card_detect_one <= 1'b1;
    pdone[1] <= 1'b1;
    @(posedge clk);
    pdone[1] <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk_bit("wide func", 1'b1, func_irq[1]);
    rd(1, SPACE_SOCKET, SOCK_EVENT_OFS, 32'hf, "wide events");
    wr(1, SPACE_SOCKET, SOCK_EVENT_OFS, '0);
    rd(1, SPACE_SOCKET, SOCK_EVENT_OFS, 32'hf, "zero kept");
    wr(1, SPACE_SOCKET, SOCK_EVENT_OFS, 32'h5);
    rd(1, SPACE_SOCKET, SOCK_EVENT_OFS, 32'ha, "w1c events");
    wr(1, SPACE_SOCKET, SOCK_MASK_OFS, 32'h2);
    #1 chk_bit("detect csc", 1'b1, csc_irq[1]);
    rd(0, SPACE_SOCKET, SOCK_EVENT_OFS, 32'h2, "io detect");
    finish_test();
  end
endmodule
`default_nettype wire
